//--- rtl/burner_consts.svh
// constants of the burner sequence controller
// assumes a 20 MHz system clock and whole-second sequence timing
`ifndef BURNER_CONSTS_SVH
`define BURNER_CONSTS_SVH

`define CLK_NS 50
`define SEC_NS 1000000000

// sequence intervals in seconds
`define RUNUP_S 8'h0c
`define SPARK_S 8'h01
`define START_TMO_S 8'h19
`define RUNDOWN_S 8'h78
`define FLAMEOUT_S 8'h0a
`define LOWV_S 8'h0c
`define LATE_FLAME_S 8'h1e
`define EXT_S 8'h5a
`define BURN_TGT_S 8'h78
`define SEC_MAX 8'hff

// threshold pairs {upper, lower} in degrees C
`define TH_BUS_AUX 16'h554e
`define TH_BUS_PARK 16'h5546
`define TH_BUS_ECO 16'h4637
`define TH_STD_AUX 16'h5546
`define TH_STD_PARK 16'h3c2d
`define TH_STD_ECO 16'h1405
`define TH_JES_AUX 16'h554b
`define TH_JES_PARK 16'h5546
`define TH_JES_ECO 16'h3228

// hysteresis adaptation and gradient evaluation, degrees C / kelvin
`define LO_START 8'h4e
`define LO_MAX 8'h50
`define LO_MIN 8'h46
`define LO_STEP 8'h01
`define GRAD_RISE_K 8'h02
`define GRAD_DROP_K 8'h05

// lockout limits
`define START_FAIL_MAX 4'h8
`define FLAMEOUT_MAX 4'h5

`endif

//--- rtl/burner_pkg.sv
// types of the burner sequence controller
// used together with burner_consts.svh
package burner_pkg;
    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_RUNUP = 3'h1,
        ST_SPARK = 3'h3,
        ST_START = 3'h2,
        ST_HEAT = 3'h6,
        ST_IDLE = 3'h7,
        ST_RUNDOWN = 3'h5,
        ST_ERROR = 3'h4
    } state_t;

    typedef enum logic [1:0] {
        VAR_BUS = 2'h0,
        VAR_RAIL_STD = 2'h1,
        VAR_RAIL_JES = 2'h2
    } variant_t;
endpackage : burner_pkg

//--- rtl/burner_sequence_controller.sv
// burner start, regulation, run-down and fault supervision
// all input pins except clk and rst are asynchronous to clk and pass a two-stage synchroniser
`timescale 1ns/1ns
`include "burner_consts.svh"

module burner_sequence_controller #(
    parameter int unsigned SEC_CYCLES = `SEC_NS / `CLK_NS
) (
    input wire logic clk, // 20 MHz system clock
    input wire logic rst, // asynchronous reset, active high
    input wire logic heat_req, // heater switch on
    input wire logic engine_run, // engine running terminal powered
    input wire logic psave_req, // power-save (economic) selected
    input wire logic cold, // ambient below 0 C
    input wire logic preheat_fit, // nozzle preheater fitted
    input wire logic flame, // flame sensor reports flame
    input wire logic low_volt, // supply below low-voltage level
    input wire logic power_ok, // main power present
    input wire logic tsens_short, // temperature sensor shorted
    input wire logic tsens_open, // temperature sensor open
    input wire logic fsens_short, // flame sensor shorted
    input wire logic fsens_open, // flame sensor open
    input wire logic valve_open_ckt, // solenoid valve open circuit
    input wire logic valve_short, // solenoid valve shorted
    input wire logic [7:0] temp_c, // coolant temperature, deg C
    input wire logic [1:0] variant, // threshold set selector
    input wire logic basic, // basic controller variant
    input wire logic grad_en, // gradient evaluation enabled
    output logic indicator, // operating indicator light
    output logic fan, // combustion air fan
    output logic fuel_pump, // fuel pump
    output logic circ_pump, // circulation pump
    output logic preheater, // nozzle preheater
    output logic igniter, // high-voltage ignition spark
    output logic valve, // fuel solenoid valve
    output logic aux_mode, // auxiliary heating active
    output logic power_save, // power-save active
    output logic fault, // error state held
    output logic lockout // repeated-failure lockout
);
    localparam int IN_W = 26;
    logic [IN_W-1:0] pins, s1_q, s2_q;
    logic s_req, s_eng, s_ps, s_cold, s_pfit, s_flame, s_lowv, s_pwr;
    logic s_ts, s_to, s_fs, s_fo, s_vo, s_vs, s_basic, s_grad;
    logic [7:0] s_temp;
    logic [1:0] s_var;

    assign pins = {heat_req, engine_run, psave_req, cold, preheat_fit,
                   flame, low_volt, power_ok, tsens_short, tsens_open,
                   fsens_short, fsens_open, valve_open_ckt, valve_short,
                   temp_c, variant, basic, grad_en};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
        end
    end

    assign {s_req, s_eng, s_ps, s_cold, s_pfit, s_flame, s_lowv, s_pwr,
            s_ts, s_to, s_fs, s_fo, s_vo, s_vs, s_temp, s_var, s_basic,
            s_grad} = s2_q;

    // seconds timebase
    logic [31:0] pre_q;
    logic tick_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_q <= '0;
            tick_q <= 1'b0;
        end else if (pre_q >= SEC_CYCLES - 1) begin
            pre_q <= '0;
            tick_q <= 1'b1;
        end else begin
            pre_q <= pre_q + 32'h0000_0001;
            tick_q <= 1'b0;
        end
    end

    burner_pkg::state_t state_q, state_d;
    logic [7:0] sec_q, absent_q, lowv_q, err_len_q, lo_q, prev_q;
    logic [3:0] sfail_q, fout_q;
    logic err_q, lock_q, adapted_q, grad_q;
    logic [15:0] pair;
    logic [7:0] upper, lower;
    logic late_flame, start_fail, heat_fail, sw_fault, go;

    // threshold selection
    always_comb begin
        pair = `TH_BUS_PARK;
        case (burner_pkg::variant_t'(s_var))
            burner_pkg::VAR_RAIL_STD: begin
                pair = s_eng ? `TH_STD_AUX :
                       s_ps ? `TH_STD_ECO : `TH_STD_PARK;
            end
            burner_pkg::VAR_RAIL_JES: begin
                pair = s_eng ? `TH_JES_AUX :
                       s_ps ? `TH_JES_ECO : `TH_JES_PARK;
            end
            default: begin
                pair = s_eng ? `TH_BUS_AUX :
                       s_ps ? `TH_BUS_ECO : `TH_BUS_PARK;
            end
        endcase
        upper = grad_q ? pair[15:8] - `GRAD_DROP_K : pair[15:8];
        lower = (s_eng && adapted_q) ? lo_q : pair[7:0];
    end

    assign late_flame = s_flame && sec_q > `LATE_FLAME_S;
    assign sw_fault = s_basic && (s_ts || s_to || s_fs || s_fo || s_vo);
    assign go = s_req && !err_q && !lock_q;
    assign start_fail = s_flame ||
        (sec_q >= `START_TMO_S - `RUNUP_S - `SPARK_S);
    assign heat_fail = absent_q > `FLAMEOUT_S ||
        (s_basic && lowv_q >= `LOWV_S) ||
        (s_basic && (s_to || s_fs || s_vs));

    always_comb begin
        state_d = state_q;
        case (state_q)
            burner_pkg::ST_OFF: begin
                if (go) begin
                    state_d = sw_fault ? burner_pkg::ST_ERROR
                                       : burner_pkg::ST_RUNUP;
                end
            end
            burner_pkg::ST_RUNUP: begin
                if (!s_req) state_d = burner_pkg::ST_RUNDOWN;
                else if (s_flame) state_d = burner_pkg::ST_ERROR;
                else if (sec_q >= `RUNUP_S) state_d = burner_pkg::ST_SPARK;
            end
            burner_pkg::ST_SPARK: begin
                if (!s_req) state_d = burner_pkg::ST_RUNDOWN;
                else if (s_flame) state_d = burner_pkg::ST_ERROR;
                else if (sec_q >= `SPARK_S) state_d = burner_pkg::ST_START;
            end
            burner_pkg::ST_START: begin
                if (!s_req) state_d = burner_pkg::ST_RUNDOWN;
                else if (s_flame) state_d = burner_pkg::ST_HEAT;
                else if (start_fail) state_d = burner_pkg::ST_ERROR;
            end
            burner_pkg::ST_HEAT: begin
                if (!s_req) state_d = burner_pkg::ST_RUNDOWN;
                else if (heat_fail) state_d = burner_pkg::ST_ERROR;
                else if (s_temp > upper) state_d = burner_pkg::ST_IDLE;
            end
            burner_pkg::ST_IDLE: begin
                if (!s_req) state_d = burner_pkg::ST_RUNDOWN;
                else if (late_flame || (s_basic && s_ts)) begin
                    state_d = burner_pkg::ST_ERROR;
                end else if (s_temp < lower) begin
                    state_d = burner_pkg::ST_RUNUP;
                end
            end
            burner_pkg::ST_RUNDOWN: begin
                if (go) state_d = burner_pkg::ST_RUNUP;
                else if (late_flame) state_d = burner_pkg::ST_ERROR;
                else if (sec_q >= `RUNDOWN_S) state_d = burner_pkg::ST_OFF;
            end
            default: begin
                if (sec_q >= err_len_q) state_d = burner_pkg::ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) state_q <= burner_pkg::ST_OFF;
        else state_q <= state_d;
    end

    // seconds in current state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) sec_q <= '0;
        else if (state_d != state_q) sec_q <= '0;
        else if (tick_q && sec_q != `SEC_MAX) sec_q <= sec_q + 8'h01;
    end

    // flame-absent and low-voltage seconds while heating
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            absent_q <= '0;
            lowv_q <= '0;
        end else if (state_q != burner_pkg::ST_HEAT) begin
            absent_q <= '0;
            lowv_q <= '0;
        end else begin
            if (s_flame) absent_q <= '0;
            else if (tick_q && absent_q != `SEC_MAX)
                absent_q <= absent_q + 8'h01;
            if (!s_lowv) lowv_q <= '0;
            else if (tick_q && lowv_q != `SEC_MAX)
                lowv_q <= lowv_q + 8'h01;
        end
    end

    // gradient evaluation
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_q <= '0;
            grad_q <= 1'b0;
        end else begin
            if (tick_q) prev_q <= s_temp;
            if (state_q != burner_pkg::ST_HEAT) grad_q <= 1'b0;
            else if (tick_q && s_grad && s_temp > prev_q &&
                     s_temp - prev_q >= `GRAD_RISE_K) grad_q <= 1'b1;
        end
    end

    // hysteresis adaptation in auxiliary mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lo_q <= `LO_START;
            adapted_q <= 1'b0;
        end else if (!s_eng) begin
            lo_q <= `LO_START;
            adapted_q <= 1'b0;
        end else if (state_q == burner_pkg::ST_HEAT &&
                     state_d == burner_pkg::ST_IDLE) begin
            adapted_q <= 1'b1;
            if (!adapted_q) lo_q <= `LO_START;
            else if (sec_q > `BURN_TGT_S && lo_q < `LO_MAX)
                lo_q <= lo_q + `LO_STEP;
            else if (sec_q < `BURN_TGT_S && lo_q > `LO_MIN)
                lo_q <= lo_q - `LO_STEP;
        end
    end

    // error flag, lockout counters and error run-down length
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_q <= 1'b0;
            lock_q <= 1'b0;
            sfail_q <= '0;
            fout_q <= '0;
            err_len_q <= `RUNDOWN_S;
        end else begin
            if (state_d == burner_pkg::ST_ERROR &&
                state_q != burner_pkg::ST_ERROR) begin
                err_q <= 1'b1;
                err_len_q <= late_flame ? `EXT_S : `RUNDOWN_S;
                if (state_q == burner_pkg::ST_HEAT)
                    fout_q <= fout_q + 4'h1;
                else if (state_q != burner_pkg::ST_IDLE &&
                         state_q != burner_pkg::ST_RUNDOWN)
                    sfail_q <= sfail_q + 4'h1;
            end else if (!s_req) begin
                err_q <= 1'b0;
            end
            if (state_q == burner_pkg::ST_HEAT) sfail_q <= '0;
            if (state_q == burner_pkg::ST_IDLE) fout_q <= '0;
            // set only on reaching the limit, so the clear below can act
            if (!lock_q && (sfail_q >= `START_FAIL_MAX ||
                            fout_q >= `FLAMEOUT_MAX)) begin
                lock_q <= 1'b1;
            end else if (state_q == burner_pkg::ST_ERROR && s_req && !s_pwr)
            begin
                lock_q <= 1'b0;
                sfail_q <= '0;
                fout_q <= '0;
            end
        end
    end

    // actuator outputs
    logic run, burn;
    assign run = state_q == burner_pkg::ST_RUNUP ||
                 state_q == burner_pkg::ST_SPARK ||
                 state_q == burner_pkg::ST_START;
    assign burn = run || state_q == burner_pkg::ST_HEAT;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            indicator <= 1'b0;
            fan <= 1'b0;
            fuel_pump <= 1'b0;
            circ_pump <= 1'b0;
            preheater <= 1'b0;
            igniter <= 1'b0;
            valve <= 1'b0;
        end else begin
            indicator <= burn || state_q == burner_pkg::ST_IDLE;
            fan <= burn || state_q == burner_pkg::ST_RUNDOWN ||
                   state_q == burner_pkg::ST_ERROR ||
                   (state_q == burner_pkg::ST_IDLE &&
                    sec_q < `RUNDOWN_S);
            fuel_pump <= burn;
            circ_pump <= state_q != burner_pkg::ST_OFF;
            preheater <= run && s_cold && s_pfit;
            igniter <= state_q == burner_pkg::ST_SPARK ||
                       state_q == burner_pkg::ST_START;
            valve <= state_q == burner_pkg::ST_START ||
                     state_q == burner_pkg::ST_HEAT;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aux_mode <= 1'b0;
            power_save <= 1'b0;
            fault <= 1'b0;
            lockout <= 1'b0;
        end else begin
            aux_mode <= s_eng;
            power_save <= s_ps && !s_eng;
            fault <= err_q;
            lockout <= lock_q;
        end
    end

    a_spark_after_runup: assert property (@(posedge clk) disable iff (rst)
        (state_q == burner_pkg::ST_SPARK &&
         $past(state_q) == burner_pkg::ST_RUNUP) |-> $past(sec_q) >= `RUNUP_S)
        else $error("spark enabled before run-up");
    a_valve_after_spark: assert property (@(posedge clk) disable iff (rst)
        $rose(valve) |-> $past(igniter))
        else $error("valve opened without spark");
    a_igniter_off_flame: assert property (@(posedge clk) disable iff (rst)
        state_q == burner_pkg::ST_HEAT |=> !igniter && valve)
        else $error("igniter still on while heating");
    a_idle_outputs: assert property (@(posedge clk) disable iff (rst)
        state_q == burner_pkg::ST_IDLE |=> !valve && circ_pump && indicator)
        else $error("idle outputs wrong");
    a_switch_off: assert property (@(posedge clk) disable iff (rst)
        state_q == burner_pkg::ST_HEAT && !s_req |=>
        state_q == burner_pkg::ST_RUNDOWN ##1 !indicator && !valve)
        else $error("switch-off not taken");
    a_aux_no_psave: assert property (@(posedge clk) disable iff (rst)
        aux_mode |-> !power_save)
        else $error("power-save active in aux mode");
    a_lower_bounds: assert property (@(posedge clk) disable iff (rst)
        lo_q >= `LO_MIN && lo_q <= `LO_MAX)
        else $error("aux lower point out of range");
    a_lock_blocks: assert property (@(posedge clk) disable iff (rst)
        lock_q && state_q == burner_pkg::ST_OFF |=>
        state_q == burner_pkg::ST_OFF)
        else $error("start attempted in lockout");
    a_error_indicator: assert property (@(posedge clk) disable iff (rst)
        state_q == burner_pkg::ST_ERROR |=> !indicator && fan && circ_pump)
        else $error("failure outputs wrong");
endmodule : burner_sequence_controller

//--- testbench/burner_plant.sv
// far-side model: flame sensor answering fuel valve and spark
// assumes controller outputs settle on rising clk edges
`timescale 1ns/1ns
module burner_plant (
    input wire logic clk, // system clock
    input wire logic valve, // fuel valve from controller
    input wire logic igniter, // spark from controller
    input wire logic flame_en, // bench lets the fuel catch
    output logic flame // flame sensor level
);
    logic [1:0] dly_q;
    initial begin
        dly_q = 2'h0;
        flame = 1'b0;
    end
    // lights two cycles after spray meets spark, dies with the fuel
    always @(negedge clk) begin
        dly_q <= {dly_q[0], valve && flame_en && (igniter || flame)};
        flame <= dly_q[1] && valve && flame_en;
    end
endmodule : burner_plant

//--- testbench/testbench.sv
// self-checking bench of the burner sequence controller
// assumes burner_plant as the flame sensor, one second = 10 clocks
`timescale 1ns/1ns
module testbench;
    localparam int SEC = 10;
    localparam int F_IND = 0;
    localparam int F_FAN = 1;
    localparam int F_FP = 2;
    localparam int F_IGN = 5;
    localparam int F_VLV = 6;
    localparam int F_AUX = 7;
    localparam int F_FLT = 9;
    logic clk, rst, heat_req, engine_run, psave_req, cold, preheat_fit;
    logic flame, power_ok, basic, flame_en;
    logic [4:0] sf;
    logic [7:0] temp_c;
    logic indicator, fan, fuel_pump, circ_pump, preheater, igniter, valve;
    logic aux_mode, power_save, fault, lockout;
    logic [10:0] obs;
    int errors, tests_run, n;

    assign obs = {lockout, fault, power_save, aux_mode, valve, igniter,
        preheater, circ_pump, fuel_pump, fan, indicator};

    always #25 clk = ~clk;

    burner_sequence_controller #(.SEC_CYCLES(SEC))
    burner_sequence_controller_inst (
        .clk(clk), .rst(rst), .heat_req(heat_req),
        .engine_run(engine_run), .psave_req(psave_req), .cold(cold),
        .preheat_fit(preheat_fit), .flame(flame), .low_volt(1'b0),
        .power_ok(power_ok), .tsens_short(sf[0]), .tsens_open(sf[1]),
        .fsens_short(sf[2]), .fsens_open(sf[3]),
        .valve_open_ckt(sf[4]), .valve_short(1'b0), .temp_c(temp_c),
        .variant(2'h0), .basic(basic), .grad_en(1'b0),
        .indicator(indicator), .fan(fan), .fuel_pump(fuel_pump),
        .circ_pump(circ_pump), .preheater(preheater),
        .igniter(igniter), .valve(valve), .aux_mode(aux_mode),
        .power_save(power_save), .fault(fault), .lockout(lockout)
    );

    burner_plant burner_plant_inst (
        .clk(clk), .valve(valve), .igniter(igniter),
        .flame_en(flame_en), .flame(flame)
    );

    task automatic wt(input int b, input logic v, input int mx);
        n = 0;
        while (obs[b] !== v && n < mx) begin
            @(negedge clk);
            n++;
        end
        if (n >= mx) begin
            errors++;
            $display("BAD %0t: wait timed out on output %0d", $time, b);
            tally_and_finish();
        end
    endtask : wt

    task automatic ck(input logic got, input logic exp, input string m);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t: %s", $time, m);
        end
    endtask : ck

    task automatic rng(input int lo, input int hi, input string m);
        tests_run++;
        if (n < lo || n > hi) begin
            errors++;
            $display("BAD %0t: %s took %0d cycles", $time, m, n);
        end
    endtask : rng

    task automatic t_sensor;
        basic = 1'b1;
        for (int i = 0; i < 5; i++) begin
            sf[i] = 1'b1;
            heat_req = 1'b1;
            wt(F_FLT, 1'b1, 10);
            sf[i] = 1'b0;
            ck(indicator, 1'b0, "light on after sensor fault");
            wt(F_FAN, 1'b1, 4);
            wt(F_FAN, 1'b0, 1300);
            rng(1185, 1215, "error run-down");
            ck(fault, 1'b1, "error dropped while on");
            heat_req = 1'b0;
            repeat (4) @(negedge clk);
            ck(fault, 1'b0, "error kept after off");
        end
        basic = 1'b0;
        $display("t_sensor done");
    endtask : t_sensor

    task automatic t_start;
        cold = 1'b1;
        preheat_fit = 1'b1;
        heat_req = 1'b1;
        wt(F_IND, 1'b1, 8);
        ck(fan & fuel_pump & circ_pump, 1'b1, "run-up outputs");
        ck(preheater, 1'b1, "preheater when cold");
        wt(F_IGN, 1'b1, 140);
        rng(110, 122, "run-up");
        ck(valve, 1'b0, "valve before spark");
        wt(F_VLV, 1'b1, 15);
        rng(8, 12, "spark to valve");
        wt(F_IGN, 1'b0, 14);
        rng(1, 10, "flame to spark off");
        cold = 1'b0;
        $display("t_start done");
    endtask : t_start

    task automatic t_regulate;
        psave_req = 1'b1;
        temp_c = 8'h4b;
        wt(F_VLV, 1'b0, 8);
        ck(valve, 1'b0, "no idle above upper point");
        ck(circ_pump & indicator & fan, 1'b1, "idle outputs");
        temp_c = 8'h3c;
        wt(F_FAN, 1'b0, 1300);
        rng(1185, 1215, "idle fan run-down");
        ck(fuel_pump, 1'b0, "restart above lower point");
        ck(circ_pump, 1'b1, "pump off in idle");
        temp_c = 8'h32;
        wt(F_FP, 1'b1, 8);
        ck(fan, 1'b1, "no restart below lower point");
        wt(F_VLV, 1'b1, 160);
        wt(F_IGN, 1'b0, 14);
        $display("t_regulate done");
    endtask : t_regulate

    task automatic t_mode;
        ck(power_save, 1'b1, "power-save not active");
        engine_run = 1'b1;
        wt(F_AUX, 1'b1, 8);
        repeat (2) @(negedge clk);
        ck(power_save, 1'b0, "power-save kept in aux");
        engine_run = 1'b0;
        wt(F_AUX, 1'b0, 8);
        psave_req = 1'b0;
        $display("t_mode done");
    endtask : t_mode

    task automatic t_off;
        heat_req = 1'b0;
        wt(F_IND, 1'b0, 8);
        ck(valve, 1'b0, "fuel after switch-off");
        ck(fan, 1'b1, "fan stopped at switch-off");
        repeat (300) @(negedge clk);
        heat_req = 1'b1;
        wt(F_FP, 1'b1, 8);
        ck(indicator, 1'b1, "restart in run-down");
        wt(F_IGN, 1'b1, 140);
        rng(110, 122, "run-up after restart");
        wt(F_IGN, 1'b0, 30);
        heat_req = 1'b0;
        wt(F_IND, 1'b0, 8);
        wt(F_FAN, 1'b0, 1300);
        rng(1185, 1215, "switch-off run-down");
        ck(circ_pump, 1'b0, "pump after run-down");
        $display("t_off done");
    endtask : t_off

    task automatic t_flameout;
        heat_req = 1'b1;
        wt(F_IND, 1'b1, 8);
        wt(F_IGN, 1'b1, 140);
        wt(F_IGN, 1'b0, 30);
        flame_en = 1'b0;
        wt(F_FLT, 1'b1, 200);
        rng(100, 120, "flame-out failure");
        repeat (2) @(negedge clk);
        ck(valve, 1'b0, "fuel after flame-out");
        ck(lockout, 1'b0, "lockout after one flame-out");
        wt(F_FAN, 1'b0, 1300);
        heat_req = 1'b0;
        repeat (4) @(negedge clk);
        ck(fault, 1'b0, "error kept after off");
        flame_en = 1'b1;
        $display("t_flameout done");
    endtask : t_flameout

    task automatic t_lock;
        flame_en = 1'b0;
        for (int i = 0; i < 8; i++) begin
            heat_req = 1'b1;
            wt(F_IND, 1'b1, 8);
            wt(F_FLT, 1'b1, 300);
            rng(240, 270, "no-flame failure");
            repeat (2) @(negedge clk);
            ck(indicator, 1'b0, "light on after failure");
            ck(lockout, i == 7, "lockout count");
            if (i < 7) begin
                wt(F_FAN, 1'b0, 1300);
                heat_req = 1'b0;
                repeat (4) @(negedge clk);
            end
        end
        power_ok = 1'b0;
        repeat (6) @(negedge clk);
        ck(lockout, 1'b0, "lockout not cleared");
        power_ok = 1'b1;
        $display("t_lock done");
    endtask : t_lock

    task automatic tally_and_finish;
        $display("tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        heat_req = 1'b0;
        engine_run = 1'b0;
        psave_req = 1'b0;
        cold = 1'b0;
        preheat_fit = 1'b0;
        power_ok = 1'b1;
        basic = 1'b0;
        flame_en = 1'b1;
        sf = 5'h00;
        temp_c = 8'h14;
        errors = 0;
        tests_run = 0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        t_sensor();
        t_start();
        t_regulate();
        t_mode();
        t_off();
        t_flameout();
        t_lock();
        tally_and_finish();
    end
endmodule : testbench
